// ===== rtl/pin_pullup_clockout_mux.sv
// Operation
// R1: Pull-up disable register, one bit per group.
// R2: Bits 14, 7, 8 drive fault pull-ups.
// R3: Bits 13..9 drive CAN, strap, reset, IRQ, boot.
// R4: Bit 5 strobes, bit 3 JTAG pull-ups.
// R5: Reserved pull-up bits read zero, ignore writes.
// R6: Port B GPIO when enable low; alt bits otherwise.
// R7: Bit 9 picks address or oscillator, pin 7.
// R8: Bit 8 picks address or second clock, pin 6.
// R9: Bit 7 picks address or system clock, pin 5.
// R10: Bit 6 picks address or prescaler, pin 4.
// R11: Bit 5 tristates clock-out pin, resets one.
// R12: Five-bit field selects clock-out source.
// R13: Other codes route factory-test internal clocks.
// R14: Software keeps clock-out on system clock.
// R15: Port C GPIO when enable low, direction bit.
// R16: Port C resets to decoder/timer function.
// R17: Select bit routes decoder/timer or SPI.
// R18: Timer output enable sets decoder/timer direction.
// R19: SPI unit sets direction in SPI routing.
// R20: Each port C pin controlled independently.
// R21: Select bits map SPI signals to pins.
`timescale 1ns/1ps
`default_nettype none
`include "pin_mux_regs.svh"

module pin_pullup_clockout_mux (
  // Clock and reset
  input wire logic SYSTEM_CLOCK,
  input wire logic RST,
  // Register port
  input wire logic [7:0] ADDR,
  input wire logic [15:0] WR_DATA,
  input wire logic WR_EN,
  input wire logic RD_EN,
  output logic [15:0] RD_DATA,
  // Internal clocks, indexed by source code
  input wire logic [`SRC_COUNT-1:0] CLK_SRC,
  // Pull-up controls to the pads
  output pin_mux_pkg::pullup_off_s PULLUP_OFF,
  // Clock-out pin
  output logic CLOCK_OUT_PIN_O,
  output logic CLOCK_OUT_PIN_OE,
  // Port B pins 7..4
  input wire pin_mux_pkg::port_b_ctl_s PORT_B_CTL,
  output logic [3:0] PORT_B_O,
  output logic [3:0] PORT_B_OE,
  // Port C pins 3..0
  input wire pin_mux_pkg::port_c_ctl_s PORT_C_CTL,
  input wire logic [3:0] PAD_C_I,
  output logic [3:0] PAD_C_O,
  output logic [3:0] PAD_C_OE,
  output pin_mux_pkg::port_c_in_s PORT_C_IN
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [15:0] pullup_disable;
    logic [15:0] clock_out_select;
    logic [15:0] port_c_function_select;
    logic [15:0] rd_data;
    logic [`SRC_COUNT-1:0] clk_meta;
    logic [`SRC_COUNT-1:0] clk_sync;
    logic [3:0] pad_meta;
    logic [3:0] pad_sync;
    pin_mux_pkg::pullup_off_s pullup_off;
    logic clk_pin_o;
    logic clk_pin_oe;
    logic [3:0] port_b_o;
    logic [3:0] port_b_oe;
    logic [3:0] pad_c_o;
    logic [3:0] pad_c_oe;
    pin_mux_pkg::port_c_in_s port_c_in;
  } state_s;

  state_s q;
  state_s d;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Codes above the table give a quiet low level
  function automatic logic pick_clock(
    input logic [4:0] code,
    input logic [`SRC_COUNT-1:0] srcs
  );
    logic result;
    result = 1'b0;
    if (code < 5'(`SRC_COUNT)) begin
      result = srcs[code];
    end
    return result;
  endfunction

  function automatic logic [4:0] port_b_alt_code(input int idx);
    logic [4:0] code;
    case (idx)
      3: code = `SRC_OSC;
      2: code = `SRC_SYSTEM2;
      1: code = `SRC_SYSTEM;
      default: code = `SRC_PRESCALE;
    endcase
    return code;
  endfunction

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    d = q;

    // Clocks and pad levels are foreign to this domain
    d.clk_meta = CLK_SRC;
    d.clk_sync = q.clk_meta;
    d.pad_meta = PAD_C_I;
    d.pad_sync = q.pad_meta;

    // Register writes
    if (WR_EN) begin
      case (ADDR)
        `PUD_OFFSET: begin
          d.pullup_disable = WR_DATA & `PUD_WMASK; // [R1] [R5]
        end
        `CKO_OFFSET: begin
          d.clock_out_select = WR_DATA & `CKO_WMASK; // [R12]
        end
        `GPS_OFFSET: begin
          d.port_c_function_select = WR_DATA & `GPS_WMASK; // [R21]
        end
        default: begin
          d.pullup_disable = q.pullup_disable;
        end
      endcase
    end

    // Read data stands only in the cycle after the strobe
    d.rd_data = 16'h0000;
    if (RD_EN) begin
      case (ADDR)
        `PUD_OFFSET: begin
          d.rd_data = q.pullup_disable & `PUD_WMASK; // [R5]
        end
        `CKO_OFFSET: begin
          d.rd_data = q.clock_out_select & `CKO_WMASK;
        end
        `GPS_OFFSET: begin
          d.rd_data = q.port_c_function_select & `GPS_WMASK;
        end
        default: begin
          d.rd_data = 16'h0000;
        end
      endcase
    end

    // Pull-up controls
    d.pullup_off.pwm_a_fault_hi_pullup_off = q.pullup_disable[14]; // [R2]
    d.pullup_off.pwm_b_fault_pullup_off = q.pullup_disable[8]; // [R2]
    d.pullup_off.pwm_a_fault_lo_pullup_off = q.pullup_disable[7]; // [R2]
    d.pullup_off.can_rx = q.pullup_disable[13]; // [R3]
    d.pullup_off.ext_mem_strap = q.pullup_disable[12]; // [R3]
    d.pullup_off.reset_pin = q.pullup_disable[11]; // [R3]
    d.pullup_off.irq_pins = q.pullup_disable[10]; // [R3]
    d.pullup_off.boot_strap_pullup_off = q.pullup_disable[9]; // [R3]
    d.pullup_off.strobes = q.pullup_disable[5]; // [R4]
    d.pullup_off.jtag = q.pullup_disable[3]; // [R4]

    // Clock-out pin; test codes pass through like any other
    d.clk_pin_oe = ~q.clock_out_select[`CKO_TRI_BIT]; // [R11]
    d.clk_pin_o = 1'b0;
    if (!q.clock_out_select[`CKO_TRI_BIT]) begin
      d.clk_pin_o = pick_clock(q.clock_out_select[`CKO_SRC_MSB:0], q.clk_sync); // [R12] [R13]
    end

    // Port B pins 7..4, index 3 is pin 7
    for (int i = 0; i < 4; i++) begin
      if (PORT_B_CTL.port_b_periph_enable[i]) begin
        d.port_b_oe[i] = 1'b1;
        if (q.clock_out_select[`CKO_ALT_LSB + i]) begin
          d.port_b_o[i] = pick_clock(port_b_alt_code(i), q.clk_sync); // [R7] [R8] [R9] [R10]
        end else begin
          d.port_b_o[i] = PORT_B_CTL.addr_hi[i]; // [R10]
        end
      end else begin
        d.port_b_oe[i] = PORT_B_CTL.gpio_dir[i]; // [R6]
        d.port_b_o[i] = PORT_B_CTL.gpio_out[i]; // [R6]
      end
    end

    // Port C pins, each with its own controls
    for (int i = 0; i < 4; i++) begin // [R20]
      d.port_c_in.gpio_in[i] = q.pad_sync[i];
      d.port_c_in.decoder_in[i] = 1'b0;
      d.port_c_in.timer_in[i] = 1'b0;
      d.port_c_in.spi_in[i] = 1'b0;
      if (!PORT_C_CTL.port_c_periph_enable[i]) begin
        d.pad_c_oe[i] = PORT_C_CTL.port_c_direction[i]; // [R15]
        d.pad_c_o[i] = PORT_C_CTL.gpio_out[i]; // [R15]
      end else if (!q.port_c_function_select[i]) begin
        // Decoder keeps watching the pin even while the timer drives it
        d.pad_c_oe[i] = PORT_C_CTL.timer_output_enable[i]; // [R18] [R17]
        d.pad_c_o[i] = PORT_C_CTL.timer_out[i]; // [R18]
        d.port_c_in.decoder_in[i] = q.pad_sync[i]; // [R18]
        d.port_c_in.timer_in[i] = q.pad_sync[i] & ~PORT_C_CTL.timer_output_enable[i];
      end else begin
        d.pad_c_oe[i] = PORT_C_CTL.spi_oe[i]; // [R19] [R17] [R21]
        d.pad_c_o[i] = PORT_C_CTL.spi_out[i]; // [R19]
        d.port_c_in.spi_in[i] = q.pad_sync[i]; // [R21]
      end
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge SYSTEM_CLOCK or posedge RST) begin
    if (RST) begin
      q.pullup_disable <= `PUD_RESET; // [R1]
      q.clock_out_select <= `CKO_RESET; // [R10] [R11] [R12]
      q.port_c_function_select <= `GPS_RESET; // [R16]
      q.rd_data <= 16'h0000;
      q.clk_meta <= '0;
      q.clk_sync <= '0;
      q.pad_meta <= 4'h0;
      q.pad_sync <= 4'h0;
      q.pullup_off <= '0;
      q.clk_pin_o <= 1'b0;
      q.clk_pin_oe <= 1'b0;
      q.port_b_o <= 4'h0;
      q.port_b_oe <= 4'h0;
      q.pad_c_o <= 4'h0;
      q.pad_c_oe <= 4'h0;
      q.port_c_in <= '0;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign RD_DATA = q.rd_data;
  assign PULLUP_OFF = q.pullup_off;
  assign CLOCK_OUT_PIN_O = q.clk_pin_o;
  assign CLOCK_OUT_PIN_OE = q.clk_pin_oe;
  assign PORT_B_O = q.port_b_o;
  assign PORT_B_OE = q.port_b_oe;
  assign PAD_C_O = q.pad_c_o;
  assign PAD_C_OE = q.pad_c_oe;
  assign PORT_C_IN = q.port_c_in;

endmodule

`default_nettype wire

// ===== rtl/pin_mux_regs.svh
`ifndef PIN_MUX_REGS_SVH
`define PIN_MUX_REGS_SVH

// ----------------------------------------
// Register word offsets
// ----------------------------------------
`define PUD_OFFSET 8'h08
`define CKO_OFFSET 8'h0A
`define GPS_OFFSET 8'h0B

// ----------------------------------------
// Writable bits and reset values
// ----------------------------------------
`define PUD_WMASK 16'h7FA8
`define PUD_RESET 16'h0000
`define CKO_WMASK 16'h03FF
`define CKO_RESET 16'h0020
`define GPS_WMASK 16'h000F
`define GPS_RESET 16'h0000

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CKO_ALT_LSB 6
`define CKO_TRI_BIT 5
`define CKO_SRC_MSB 4

// ----------------------------------------
// Clock source codes
// ----------------------------------------
`define SRC_SYSTEM 5'h00
`define SRC_OSC 5'h07
`define SRC_SYNTH 5'h08
`define SRC_PRESCALE 5'h0B
`define SRC_SYSTEM2 5'h0D
`define SRC_CONV_A 5'h10
`define SRC_CONV_B 5'h11
`define SRC_COUNT 18

`endif

// ===== rtl/pin_mux_pkg.sv
package pin_mux_pkg;

  typedef struct packed {
    logic pwm_a_fault_hi_pullup_off;
    logic can_rx;
    logic ext_mem_strap;
    logic reset_pin;
    logic irq_pins;
    logic boot_strap_pullup_off;
    logic pwm_b_fault_pullup_off;
    logic pwm_a_fault_lo_pullup_off;
    logic strobes;
    logic jtag;
  } pullup_off_s;

  typedef struct packed {
    logic [3:0] port_b_periph_enable;
    logic [3:0] gpio_dir;
    logic [3:0] gpio_out;
    logic [3:0] addr_hi;
  } port_b_ctl_s;

  typedef struct packed {
    logic [3:0] port_c_periph_enable;
    logic [3:0] port_c_direction;
    logic [3:0] gpio_out;
    logic [3:0] timer_output_enable;
    logic [3:0] timer_out;
    logic [3:0] spi_oe;
    logic [3:0] spi_out;
  } port_c_ctl_s;

  typedef struct packed {
    logic [3:0] gpio_in;
    logic [3:0] decoder_in;
    logic [3:0] timer_in;
    logic [3:0] spi_in;
  } port_c_in_s;

endpackage

// ===== dv/pin_mux_pads.sv
`timescale 1ns/1ps
`default_nettype none
module pin_mux_pads (
  // Pads and clock sources
  input wire logic SYSTEM_CLOCK,
  input wire logic [3:0] PAD_C_O,
  input wire logic [3:0] PAD_C_OE,
  input wire logic [3:0] EXT_C,
  output logic [17:0] CLK_SRC,
  output logic [3:0] PAD_C_I
);
  int cnt = 0;
  initial CLK_SRC = '0;
  // Falling-edge toggles keep the sampling free of races
  always @(negedge SYSTEM_CLOCK) begin
    cnt <= cnt + 1;
    for (int n = 0; n < 18; n++)
      if (cnt % (n + 2) == 0) CLK_SRC[n] <= ~CLK_SRC[n];
  end
  // Outside driver only shows while the pin is released
  assign PAD_C_I = (PAD_C_O & PAD_C_OE) | (EXT_C & ~PAD_C_OE);
endmodule
`default_nettype wire

// ===== dv/pin_pullup_clockout_mux_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module pin_pullup_clockout_mux_assertions (
  // Watched ports
  input wire logic SYSTEM_CLOCK,
  input wire logic RST,
  input wire logic [7:0] ADDR,
  input wire logic [15:0] WR_DATA,
  input wire logic WR_EN,
  input wire logic RD_EN,
  input wire logic [15:0] RD_DATA,
  input wire pin_mux_pkg::pullup_off_s PULLUP_OFF,
  input wire logic CLOCK_OUT_PIN_OE,
  input wire pin_mux_pkg::port_b_ctl_s PORT_B_CTL,
  input wire logic [3:0] PORT_B_OE,
  input wire pin_mux_pkg::port_c_ctl_s PORT_C_CTL,
  input wire logic [3:0] PAD_C_OE
);
  logic [15:0] wd1, wd2;
  always_ff @(posedge SYSTEM_CLOCK) begin
    wd1 <= WR_DATA;
    wd2 <= wd1;
  end
  default clocking cb @(posedge SYSTEM_CLOCK); endclocking
  default disable iff (RST);
  sequence s_pud_wr;
    WR_EN && ADDR == 8'h08;
  endsequence
  a_rd_idle: assert property (!$past(RD_EN) |-> RD_DATA == 16'h0000)
    else $error("read data not idle");
  a_pud_back: assert property (s_pud_wr ##1 RD_EN && ADDR == 8'h08 |=> RD_DATA == (wd2 & 16'h7FA8))
    else $error("pull-up readback wrong");
  a_pud_map: assert property (s_pud_wr |-> ##2 PULLUP_OFF == {wd2[14:7], wd2[5], wd2[3]})
    else $error("pull-up outputs wrong");
  a_tri_on: assert property (WR_EN && ADDR == 8'h0A && WR_DATA[5] |-> ##2 !CLOCK_OUT_PIN_OE)
    else $error("clock-out not released");
  a_tri_off: assert property (WR_EN && ADDR == 8'h0A && !WR_DATA[5] |-> ##2 CLOCK_OUT_PIN_OE)
    else $error("clock-out not driven");
  a_pb_gpio: assert property (1'b1 |=> ((PORT_B_OE ^ $past(PORT_B_CTL.gpio_dir))
    & ~$past(PORT_B_CTL.port_b_periph_enable)) == 4'h0) else $error("port B gpio enable");
  a_pb_per: assert property (PORT_B_CTL.port_b_periph_enable == 4'hF |=> PORT_B_OE == 4'hF)
    else $error("port B peripheral enable");
  a_pc_gpio: assert property (1'b1 |=> ((PAD_C_OE ^ $past(PORT_C_CTL.port_c_direction))
    & ~$past(PORT_C_CTL.port_c_periph_enable)) == 4'h0) else $error("port C gpio enable");
  c_read: cover property (RD_EN && ADDR == 8'h08);
  c_clk_pin: cover property (CLOCK_OUT_PIN_OE);
  c_pc_drive: cover property (PORT_C_CTL.port_c_periph_enable == 4'hF && PAD_C_OE != 4'h0);
endmodule
bind pin_pullup_clockout_mux pin_pullup_clockout_mux_assertions chk_i (.*);
`default_nettype wire

// ===== dv/pin_pullup_clockout_mux_tb.sv
`timescale 1ns/1ps
`default_nettype none
module pin_pullup_clockout_mux_tb;
  logic SYSTEM_CLOCK, RST, WR_EN, RD_EN, CLOCK_OUT_PIN_O, CLOCK_OUT_PIN_OE;
  logic [7:0] ADDR;
  logic [15:0] WR_DATA, RD_DATA;
  logic [17:0] CLK_SRC, p1, p2, p3;
  logic [3:0] PORT_B_O, PORT_B_OE, PAD_C_I, PAD_C_O, PAD_C_OE, EXT_C;
  pin_mux_pkg::pullup_off_s PULLUP_OFF;
  pin_mux_pkg::port_b_ctl_s PORT_B_CTL;
  pin_mux_pkg::port_c_ctl_s PORT_C_CTL;
  pin_mux_pkg::port_c_in_s PORT_C_IN;
  int err_count = 0;
  int check_count = 0;
  pin_pullup_clockout_mux pin_pullup_clockout_mux_i (.*);
  pin_mux_pads pin_mux_pads_i (.*);
  // Same depth as the synchroniser plus output flop
  always @(posedge SYSTEM_CLOCK) begin
    p1 <= CLK_SRC;
    p2 <= p1;
    p3 <= p2;
  end
  initial begin
    SYSTEM_CLOCK = 1'b0;
    forever #50 SYSTEM_CLOCK = ~SYSTEM_CLOCK;
  end
  task complete_run;
    if (err_count == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task cmp(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("mismatch t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task tk(input int n);
    repeat (n) @(posedge SYSTEM_CLOCK);
    #1;
  endtask
  // Optional write, then a read of the same word on the very next edge
  task acc(input logic [7:0] a, input logic we, input logic [15:0] d, input logic [15:0] e);
    @(posedge SYSTEM_CLOCK);
    ADDR <= a;
    WR_DATA <= d;
    WR_EN <= we;
    @(posedge SYSTEM_CLOCK);
    WR_EN <= 1'b0;
    RD_EN <= 1'b1;
    @(posedge SYSTEM_CLOCK);
    RD_EN <= 1'b0;
    #1 cmp(RD_DATA, e);
  endtask
  task t_rst;
    acc(8'h08, 1'b0, 16'h0000, 16'h0000);
    acc(8'h0A, 1'b0, 16'h0000, 16'h0020);
    acc(8'h0B, 1'b0, 16'h0000, 16'h0000);
    cmp({PULLUP_OFF, CLOCK_OUT_PIN_OE}, 11'h000);
  endtask
  task t_pu(input logic [15:0] d);
    acc(8'h08, 1'b1, d, d & 16'h7FA8);
    cmp(PULLUP_OFF, {d[14:7], d[5], d[3]});
    acc(8'h0C, 1'b1, d, 16'h0000);
  endtask
  task t_clk(input int c);
    acc(8'h0A, 1'b1, 16'(c), 16'(c));
    repeat (24) begin
      cmp({CLOCK_OUT_PIN_OE, CLOCK_OUT_PIN_O}, {1'b1, c < 18 ? p3[c] : 1'b0});
      tk(1);
    end
  endtask
  task t_pb;
    @(posedge SYSTEM_CLOCK) PORT_B_CTL <= '{4'h0, 4'hA, 4'h5, 4'h9};
    tk(2);
    cmp({PORT_B_OE, PORT_B_O}, 8'hA5);
    @(posedge SYSTEM_CLOCK) PORT_B_CTL <= '{4'hF, 4'h0, 4'h0, 4'h9};
    acc(8'h0A, 1'b1, 16'hFFFF, 16'h03FF);
    cmp({CLOCK_OUT_PIN_OE, CLOCK_OUT_PIN_O}, 2'b00);
    acc(8'h0A, 1'b1, 16'h0000, 16'h0000);
    cmp({PORT_B_OE, PORT_B_O}, 8'hF9);
    acc(8'h0A, 1'b1, 16'h03C0, 16'h03C0);
    repeat (24) begin
      tk(1);
      cmp(PORT_B_O, {p3[7], p3[13], p3[0], p3[11]});
    end
  endtask
  task t_pc(input logic [3:0] per, input logic [3:0] sel, input logic [3:0] toe,
    input logic [3:0] ext);
    logic [3:0] m, oe, o, pad;
    m = sel & per;
    oe = (4'h6 & m) | (toe & per & ~m) | (4'h9 & ~per);
    o = (4'hC & m) | (4'hA & per & ~m) | (4'h5 & ~per);
    pad = (o & oe) | (ext & ~oe);
    acc(8'h0B, 1'b1, {12'hFFF, sel}, {12'h000, sel});
    @(posedge SYSTEM_CLOCK);
    PORT_C_CTL <= '{per, 4'h9, 4'h5, toe, 4'hA, 4'h6, 4'hC};
    EXT_C <= ext;
    tk(5);
    cmp({PAD_C_OE, PAD_C_O}, {oe, o});
    cmp(PORT_C_IN, {pad, pad & per & ~m, pad & per & ~m & ~toe, pad & m});
  endtask
  initial begin
    #300000;
    err_count++;
    complete_run();
  end
  initial begin
    RST = 1'b1;
    {ADDR, WR_DATA, WR_EN, RD_EN, EXT_C, PORT_B_CTL} = '0;
    PORT_C_CTL = '{4'hF, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0};
    repeat (12) @(posedge SYSTEM_CLOCK);
    RST <= 1'b0;
    t_rst();
    t_pu(16'hFFFF);
    t_pu(16'h5555);
    t_pu(16'hAAAA);
    t_clk(0);
    t_clk(7);
    t_clk(8);
    t_clk(16);
    t_clk(17);
    t_clk(13);
    t_clk(18);
    t_pb();
    t_pc(4'h0, 4'hF, 4'h6, 4'h5);
    t_pc(4'hF, 4'h0, 4'h6, 4'h5);
    t_pc(4'hF, 4'hF, 4'h3, 4'h9);
    t_pc(4'h3, 4'h5, 4'h6, 4'hA);
    complete_run();
  end
endmodule
`default_nettype wire
